// file: nrf_filter.sv
// node request filter: set/clear bitmaps on an avalon-mm slave and the
// per-request accept and routing decision.
// assumes requests arrive synchronous to i_sys_clk, one per cycle at most,
// and that i_por_n is a power-on reset released no later than i_rst_n.
`timescale 1ns/1ps
module nrf_filter
  import nrf_pkg::*;
#(
  parameter int ADDR_W = 9
) (
  input wire logic i_sys_clk, // 250 MHz system clock
  input wire logic i_rst_n, // host bus reset, async, active low
  input wire logic i_por_n, // power-on reset, async, active low
  input wire logic [ADDR_W-1:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // low marks completion
  input wire logic [9:0] i_local_bus_id, // our own bus number
  input wire nrf_req_t i_req, // incoming request
  output nrf_dec_t o_dec // registered decision
);

  typedef enum logic [1:0] {
    NRF_BUS_IDLE = 2'b01,
    NRF_BUS_ACK = 2'b10
  } nrf_bus_state_t;

  nrf_bus_state_t state_r;
  nrf_bus_state_t state_nxt;
  logic waitreq_r;
  logic waitreq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [31:0] async_lo_r;
  logic [31:0] async_lo_nxt;
  logic [31:0] async_hi_r;
  logic [31:0] async_hi_nxt;
  logic [NRF_PHYS_NODE_W-1:0] phys_node_r;
  logic [NRF_PHYS_NODE_W-1:0] phys_node_nxt;
  logic phys_remote_r;
  logic phys_remote_nxt;
  nrf_dec_t dec_r;
  nrf_dec_t dec_nxt;

  logic req_on;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] phys_hi_view;
  logic [9:0] src_bus;
  logic [5:0] src_node;
  logic src_local;
  logic node_async_bit;
  logic node_phys_bit;

  // byte enables widened to a bit mask
  function automatic logic [31:0] nrf_be_mask(input logic [3:0] be);
    nrf_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // one node's bit out of a 64-node bitmap
  function automatic logic nrf_map_bit(input logic [63:0] map, input logic [5:0] node);
    nrf_map_bit = map[node];
  endfunction

  // read view of a register at a byte address
  function automatic logic [31:0] nrf_read(input logic [ADDR_W-1:0] a,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi,
                                           input logic [31:0] ph);
    case (a)
      NRF_ASYNC_HI_SET, NRF_ASYNC_HI_CLR: nrf_read = hi;
      NRF_ASYNC_LO_SET, NRF_ASYNC_LO_CLR: nrf_read = lo;
      NRF_PHYS_HI_SET, NRF_PHYS_HI_CLR: nrf_read = ph;
      default: nrf_read = NRF_READ_UNMAPPED;
    endcase
  endfunction

  // shared decode terms
  assign req_on = i_avs_read || i_avs_write;
  assign wr_fire = i_avs_write && (state_r == NRF_BUS_ACK);
  assign wmask = i_avs_writedata & nrf_be_mask(i_avs_byteenable);
  // physical nodes below 51 are not filtered here and read as zero
  assign phys_hi_view = {phys_remote_r, phys_node_r, 19'h0_0000};
  assign src_bus = i_req.src_id[15:6];
  assign src_node = i_req.src_id[5:0];
  assign src_local = (src_bus == NRF_LOCAL_BUS_ALIAS) || (src_bus == i_local_bus_id);
  assign node_async_bit = (src_node != NRF_BROADCAST_NODE)
                          && nrf_map_bit({async_hi_r, async_lo_r}, src_node);
  assign node_phys_bit = nrf_map_bit({1'b0, phys_node_r, 19'h0_0000, 32'h0000_0000},
                                     src_node);

  // bus handshake: take the request, answer one cycle later
  always_comb begin
    state_nxt = state_r;
    waitreq_nxt = 1'b1;
    rdata_nxt = rdata_r;
    case (state_r)
      NRF_BUS_IDLE: begin
        if (req_on) begin
          state_nxt = NRF_BUS_ACK;
          waitreq_nxt = 1'b0;
          rdata_nxt = i_avs_read ? nrf_read(i_avs_address, async_lo_r, async_hi_r,
                                            phys_hi_view) : NRF_READ_UNMAPPED;
        end
      end
      NRF_BUS_ACK: begin
        state_nxt = NRF_BUS_IDLE;
      end
      default: begin
        state_nxt = NRF_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= NRF_BUS_IDLE;
      waitreq_r <= 1'b1;
      rdata_r <= NRF_READ_UNMAPPED;
    end else begin
      state_r <= state_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // filter bitmaps: writes land at the edge where waitrequest is low
  always_comb begin
    async_lo_nxt = async_lo_r;
    async_hi_nxt = async_hi_r;
    phys_node_nxt = phys_node_r;
    phys_remote_nxt = phys_remote_r;
    if (wr_fire) begin
      case (i_avs_address)
        // RULE1 RULE13 lower async set
        NRF_ASYNC_LO_SET: async_lo_nxt = async_lo_r | wmask;
        // RULE2 RULE13 lower async clear
        NRF_ASYNC_LO_CLR: async_lo_nxt = async_lo_r & ~wmask;
        // RULE12 upper async set
        NRF_ASYNC_HI_SET: async_hi_nxt = async_hi_r | wmask;
        // RULE12 upper async clear
        NRF_ASYNC_HI_CLR: async_hi_nxt = async_hi_r & ~wmask;
        // RULE4 RULE11 upper physical set
        NRF_PHYS_HI_SET: begin
          phys_node_nxt = phys_node_r | wmask[NRF_PHYS_NODE_MSB:NRF_PHYS_NODE_LSB];
          phys_remote_nxt = phys_remote_r | wmask[NRF_REMOTE_BIT];
        end
        NRF_PHYS_HI_CLR: begin
          phys_node_nxt = phys_node_r & ~wmask[NRF_PHYS_NODE_MSB:NRF_PHYS_NODE_LSB];
          phys_remote_nxt = phys_remote_r & ~wmask[NRF_REMOTE_BIT];
        end
        default: begin
          async_lo_nxt = async_lo_r;
        end
      endcase
    end
  end

  // RULE3 bitmaps cleared by host reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      async_lo_r <= NRF_MAP_RST;
      async_hi_r <= NRF_MAP_RST;
      phys_node_r <= NRF_PHYS_NODE_RST;
    end else begin
      async_lo_r <= async_lo_nxt;
      async_hi_r <= async_hi_nxt;
      phys_node_r <= phys_node_nxt;
    end
  end

  // RULE10 remote bit only on power-on
  always_ff @(posedge i_sys_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      phys_remote_r <= NRF_REMOTE_RST;
    end else if (i_rst_n) begin
      phys_remote_r <= phys_remote_nxt;
    end
  end

  // request decision, one cycle after the request
  always_comb begin
    dec_nxt = '0;
    dec_nxt.valid = i_req.valid;
    if (i_req.valid) begin
      if (src_local) begin
        // RULE5 RULE7 async check first
        dec_nxt.accept = node_async_bit;
        // RULE4 RULE6 then physical routing
        dec_nxt.to_phys = node_async_bit && i_req.phys && node_phys_bit;
        dec_nxt.to_async = node_async_bit && !(i_req.phys && node_phys_bit);
      end else begin
        // RULE8 RULE9 remote gate
        dec_nxt.accept = phys_remote_r;
        dec_nxt.to_phys = phys_remote_r && i_req.phys;
        dec_nxt.to_async = phys_remote_r && !i_req.phys;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dec_r <= '0;
    end else begin
      dec_r <= dec_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = waitreq_r;
  assign o_dec = dec_r;

  // checks on the bitmaps and the decision
  sequence wr_done_s(logic [ADDR_W-1:0] a);
    i_avs_write && !waitreq_r && (i_avs_address == a);
  endsequence

  sequence rd_done_s(logic [ADDR_W-1:0] a);
    i_avs_read && !waitreq_r && (i_avs_address == a);
  endsequence

  sequence local_req_s;
    i_req.valid && src_local;
  endsequence

  sequence remote_req_s;
    i_req.valid && !src_local;
  endsequence

  lo_set_write_a: assert property ( // RULE1
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_done_s(NRF_ASYNC_LO_SET) |=> async_lo_r == ($past(async_lo_r) | $past(wmask)))
    else $error("lower async set write wrong");

  lo_clear_write_a: assert property ( // RULE13
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_done_s(NRF_ASYNC_LO_CLR) |=> async_lo_r == ($past(async_lo_r) & ~$past(wmask)))
    else $error("lower async clear write wrong");

  lo_read_back_a: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_avs_read && !waitreq_r && (i_avs_address == NRF_ASYNC_LO_SET
      || i_avs_address == NRF_ASYNC_LO_CLR)) |-> o_avs_readdata == async_lo_r)
    else $error("lower async read back wrong");

  reset_clear_a: assert property ( // RULE3
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> (async_lo_r == 32'h0 && async_hi_r == 32'h0 && phys_node_r == 12'h0))
    else $error("filters not zero after reset");

  phys_route_a: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (local_req_s and (node_async_bit && i_req.phys))
      |=> (o_dec.to_phys == $past(node_phys_bit)) && (o_dec.to_async == !$past(node_phys_bit)))
    else $error("physical routing wrong");

  async_gate_a: assert property ( // RULE5
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (local_req_s and !node_async_bit) |=> o_dec.valid && !o_dec.accept && !o_dec.to_phys)
    else $error("async filter not applied first");

  remote_block_a: assert property ( // RULE8
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (remote_req_s and !phys_remote_r) |=> o_dec.valid && !o_dec.accept)
    else $error("remote packet acknowledged");

  remote_accept_a: assert property ( // RULE9
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (remote_req_s and phys_remote_r) |=> o_dec.accept && (o_dec.to_phys != o_dec.to_async))
    else $error("remote packet not accepted");

  remote_keep_a: assert property ( // RULE10
    @(posedge i_sys_clk) disable iff (!i_por_n)
    !i_rst_n |=> phys_remote_r == $past(phys_remote_r))
    else $error("remote bit lost in host reset");

  // a read answered three edges after a set write is the earliest one the bench issues; the bus itself allows two
  phys_set_write_a: assert property ( // RULE11
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_done_s(NRF_PHYS_HI_SET) ##3 rd_done_s(NRF_PHYS_HI_SET)
      |-> (o_avs_readdata & $past(wmask, 3) & 32'hFFF8_0000) == ($past(wmask, 3) & 32'hFFF8_0000))
    else $error("physical set not visible");

  phys_read_back_a: assert property ( // RULE11
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    rd_done_s(NRF_PHYS_HI_SET) |-> o_avs_readdata == {phys_remote_r, phys_node_r, 19'h0_0000})
    else $error("physical read back wrong");

  hi_set_write_a: assert property ( // RULE12
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_done_s(NRF_ASYNC_HI_SET) |=> async_hi_r == ($past(async_hi_r) | $past(wmask)))
    else $error("upper async set write wrong");

  hi_clear_write_a: assert property ( // RULE12
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_done_s(NRF_ASYNC_HI_CLR) |=> async_hi_r == ($past(async_hi_r) & ~$past(wmask)))
    else $error("upper async clear write wrong");

  phys_bits_a: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (local_req_s and (i_req.phys && node_async_bit && src_node < 6'd51)) |=> !o_dec.to_phys)
    else $error("unfiltered low node routed physical");

endmodule

// file: nrf_pkg.sv
// node request filter package: register map, reset values, carrier structs.
// assumes byte addressing on the register bus, one aligned word per register.
// Contract
// RULE1 - lower async bitmap: bit n accepts async requests from local node n.
// RULE2 - lower async bitmap has set and clear words, both read back the bitmap.
// RULE3 - all filter bits leave reset at zero, so nothing is enabled.
// RULE4 - upper physical bits 30..19 route local nodes 62..51 to the physical context.
// RULE5 - physical-bound packets check async filter first, then the physical bitmap.
// RULE6 - physical bit zero sends the request to the async receive context.
// RULE7 - per-node comparison applies only to sources on the local bus.
// RULE8 - remote-bus packets go unacknowledged unless upper physical bit 31 is set.
// RULE9 - with upper physical bit 31 set, every remote-bus request is accepted.
// RULE10 - upper physical bit 31 survives host bus reset, other bits clear.
// RULE11 - upper physical bitmap has a set word at its offset, reads the bitmap.
// RULE12 - upper async bitmap covers nodes 32..62 plus remote bit, own set/clear; bit 31 here is stored but gates no request.
// RULE13 - set writes set the one bits, clear writes clear them, zeros ignored.
package nrf_pkg;

  // register byte offsets
  localparam logic [8:0] NRF_ASYNC_HI_SET = 9'h100;
  localparam logic [8:0] NRF_ASYNC_HI_CLR = 9'h104;
  localparam logic [8:0] NRF_ASYNC_LO_SET = 9'h108;
  localparam logic [8:0] NRF_ASYNC_LO_CLR = 9'h10C;
  localparam logic [8:0] NRF_PHYS_HI_SET = 9'h110;
  localparam logic [8:0] NRF_PHYS_HI_CLR = 9'h114;

  // field layout and reset values
  localparam int NRF_REMOTE_BIT = 31;
  localparam int NRF_PHYS_NODE_LSB = 19;
  localparam int NRF_PHYS_NODE_MSB = 30;
  localparam int NRF_PHYS_NODE_W = 12;
  localparam logic [31:0] NRF_MAP_RST = 32'h0000_0000;
  localparam logic [11:0] NRF_PHYS_NODE_RST = 12'h000;
  localparam logic NRF_REMOTE_RST = 1'b0;
  localparam logic [31:0] NRF_READ_UNMAPPED = 32'h0000_0000;

  // node id layout: bus in [15:6], node in [5:0]
  localparam logic [9:0] NRF_LOCAL_BUS_ALIAS = 10'h3FF;
  localparam logic [5:0] NRF_BROADCAST_NODE = 6'h3F;

  // request arriving from the serial bus receive side
  typedef struct packed {
    logic valid;
    logic phys;
    logic [15:0] src_id;
  } nrf_req_t;

  // filter decision handed to the receive contexts
  typedef struct packed {
    logic valid;
    logic accept;
    logic to_phys;
    logic to_async;
  } nrf_dec_t;

endpackage

// file: nrf_remote_nodes.sv
// remote node model: issues one-cycle requests toward the filter.
// assumes send is called from the bench, which owns the clock timing.
`timescale 1ns/1ps
module nrf_remote_nodes
  import nrf_pkg::*;
(
  input wire logic i_sys_clk, // system clock
  output nrf_req_t o_req // request toward the filter
);
  // idle lines at time zero
  initial begin
    o_req = '0;
  end
  // one request per call; id lines scramble once released
  task automatic send(input logic phys, input logic [15:0] src);
    @(posedge i_sys_clk);
    o_req <= '{valid: 1'b1, phys: phys, src_id: src};
    @(posedge i_sys_clk);
    o_req <= '{valid: 1'b0, phys: ~phys, src_id: ~src};
  endtask
endmodule

// file: tb_node_request_filter.sv
// bench for the node request filter: register traffic and request decisions.
// assumes nrf_filter and the remote node model share one 250 MHz clock.
`timescale 1ns/1ps
module tb_node_request_filter
  import nrf_pkg::*;
();
  logic clk, rst_n, por_n, rd, wr, wt;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, lo, ahi, ph;
  logic [3:0] be;
  logic [9:0] lid, rb;
  nrf_req_t req;
  nrf_dec_t dec;
  int n_mismatch, check_count, i;

  nrf_filter u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .i_local_bus_id(lid), .i_req(req),
    .o_dec(dec));
  nrf_remote_nodes u_nodes (.i_sys_clk(clk), .o_req(req));

  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
    input logic [3:0] b, output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d; be <= b;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wt === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
    if (n == 20) begin
      n_mismatch++;
      $display("[ERR] %0t bus timeout", $time);
      complete_run();
    end
  endtask

  // write and update the expected bitmaps
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] m, q;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & d;
    bus(1'b1, a, d, b, q);
    case (a)
      NRF_ASYNC_HI_SET: ahi |= m;
      NRF_ASYNC_HI_CLR: ahi &= ~m;
      NRF_ASYNC_LO_SET: lo |= m;
      NRF_ASYNC_LO_CLR: lo &= ~m;
      NRF_PHYS_HI_SET: ph |= m & 32'hFFF8_0000;
      NRF_PHYS_HI_CLR: ph &= ~m;
      default: ;
    endcase
  endtask

  function automatic logic [31:0] exp_rd(input logic [8:0] a);
    case (a)
      NRF_ASYNC_HI_SET, NRF_ASYNC_HI_CLR: return ahi;
      NRF_ASYNC_LO_SET, NRF_ASYNC_LO_CLR: return lo;
      NRF_PHYS_HI_SET, NRF_PHYS_HI_CLR: return ph;
      default: return NRF_READ_UNMAPPED;
    endcase
  endfunction

  task automatic rd_chk(input logic [8:0] a);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    chk(q, exp_rd(a));
  endtask

  // expected decision from the bitmaps
  function automatic nrf_dec_t exp_dec(input logic phys, input logic [15:0] s);
    logic [5:0] n;
    logic ab, pb, acc, tp;
    n = s[5:0];
    ab = (n < 6'd32) ? lo[n[4:0]] : (n < 6'd63) ? ahi[n[4:0]] : 1'b0;
    pb = (n >= 6'd51 && n <= 6'd62) ? ph[n[4:0]] : 1'b0;
    if (s[15:6] == lid || s[15:6] == 10'h3FF) begin
      acc = ab;
      tp = acc & phys & pb;
    end else begin
      acc = ph[31];
      tp = acc & phys;
    end
    return '{valid: 1'b1, accept: acc, to_phys: tp, to_async: acc & !tp};
  endfunction

  task automatic req_chk(input logic phys, input logic [15:0] s);
    u_nodes.send(phys, s);
    #1;
    chk({28'h0, dec}, {28'h0, exp_dec(phys, s)});
  endtask

  initial begin
    rst_n = 1'b0; por_n = 1'b0; rd = 1'b0; wr = 1'b0;
    addr = '0; wdata = '0; be = '0;
    lo = '0; ahi = '0; ph = '0;
    n_mismatch = 0; check_count = 0;
    void'($urandom(32'h49C4));
    lid = 10'($urandom_range(1, 1022));
    rb = lid - 10'h001;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1; por_n <= 1'b1;
    // reset values, the unmapped word at the end
    for (i = 0; i < 7; i++) rd_chk(9'h100 + 9'(4 * i));
    req_chk(1'b0, {lid, 6'd5});
    // lower async bitmap edges
    wr_reg(NRF_ASYNC_LO_SET, 32'hFFFF_FFFF, 4'hF);
    wr_reg(NRF_ASYNC_LO_CLR, 32'h8000_0001, 4'hF);
    rd_chk(NRF_ASYNC_LO_SET);
    rd_chk(NRF_ASYNC_LO_CLR);
    req_chk(1'b0, {lid, 6'd0});
    req_chk(1'b0, {lid, 6'd31});
    req_chk(1'b0, {lid, 6'd30});
    // physical routing for nodes 62 and 51, node 52 falls back
    wr_reg(NRF_ASYNC_HI_SET, 32'h7FFF_FFFF, 4'hF);
    wr_reg(NRF_PHYS_HI_SET, 32'h4008_0000, 4'hF);
    rd_chk(NRF_PHYS_HI_SET);
    req_chk(1'b1, {lid, 6'd62});
    req_chk(1'b1, {lid, 6'd51});
    req_chk(1'b1, {lid, 6'd52});
    req_chk(1'b1, {10'h3FF, 6'd51});
    req_chk(1'b0, {lid, 6'd63});
    // remote bus gated by the all-buses bit
    req_chk(1'b0, {rb, 6'd0});
    wr_reg(NRF_PHYS_HI_SET, 32'h8000_0000, 4'h8);
    req_chk(1'b0, {rb, 6'd63});
    req_chk(1'b1, {rb, 6'd2});
    // random register traffic and requests
    for (i = 0; i < 300; i++) begin
      addr <= addr;
      wr_reg(9'h100 + 9'(4 * $urandom_range(0, 6)), $urandom, 4'($urandom));
      rd_chk(9'h100 + 9'(4 * $urandom_range(0, 6)));
      req_chk(1'($urandom), {($urandom_range(0, 2) == 0) ? rb : lid, 6'($urandom)});
    end
    // host reset keeps only the all-buses bit
    wr_reg(NRF_PHYS_HI_SET, 32'h8010_0000, 4'hF);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    lo = '0; ahi = '0; ph &= 32'h8000_0000;
    for (i = 0; i < 6; i++) rd_chk(9'h100 + 9'(4 * i));
    req_chk(1'b0, {rb, 6'd7});
    complete_run();
  end
endmodule
